/* File: pieo_pkg.sv */
// Shared constants for the peripheral interrupt enable block
package pieo_pkg;

  // Bus geometry
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned SRC_N      = 8;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF   = 12'h080;
  localparam logic [11:0] FLAG_OFF   = 12'h084;
  localparam logic [11:0] ENABLE_OFF = 12'h08C;

  // Values after reset
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [1:0] CTRL_RST   = 2'h0;
  localparam logic [7:0] FLAG_RST   = 8'h00;

  // Main control field positions
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned GROUP_EN_BIT  = 6;

  // Source positions in the enable and flag layout
  localparam int unsigned PARALLEL_PORT_BIT  = 7;
  localparam int unsigned CONVERTER_DONE_BIT = 6;
  localparam int unsigned SERIAL_RX_BIT      = 5;
  localparam int unsigned SERIAL_TX_BIT      = 4;
  localparam int unsigned SYNC_SERIAL_BIT    = 3;
  localparam int unsigned CAPTURE_BIT        = 2;
  localparam int unsigned PERIOD_MATCH_BIT   = 1;
  localparam int unsigned TIMER_OVF_BIT      = 0;

  // Buffer-state flags follow their source instead of latching
  localparam logic [7:0] LEVEL_MASK = 8'h30;

  // Word-aligned address match
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    addr_hit = (addr[11:2] == off[11:2]);
  endfunction

endpackage

/* File: pieo_flag_bank.sv */
// Interrupt flag bits: sticky write-one-to-clear or level-following
`timescale 1ns/1ps
`default_nettype none
module pieo_flag_bank #(
  parameter int unsigned      WIDTH      = 8,
  parameter logic [WIDTH-1:0] LEVEL_BITS = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Source conditions and clear strobes
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic [WIDTH-1:0] clr,
  // Flag state
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  // Next value per bit; a set in the clear cycle is kept
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      if (LEVEL_BITS[i])
      begin : g_level
        always_comb
        begin
          flag_d[i] = cond[i];
        end
      end
      else
      begin : g_sticky
        always_comb
        begin
          flag_d[i] = cond[i] | (flag_q[i] & ~clr[i]);
        end
      end
    end
  endgenerate

  // Flag storage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= WIDTH'(pieo_pkg::FLAG_RST);
    else
      flag_q <= flag_d;
  end

  assign flags = flag_q;

endmodule
`default_nettype wire

/* File: pieo_apb_port.sv */
// APB slave front end: decode, strobes and registered read data
`timescale 1ns/1ps
`default_nettype none
module pieo_apb_port #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB request
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  // APB answer
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Register side
  input  wire logic [31:0]       rd_word,
  output logic                   sel_ctrl,
  output logic                   sel_flag,
  output logic                   sel_enable,
  output logic                   wr_stb
);

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic        mapped;
  logic        setup;

  // Address decode
  assign sel_ctrl   = pieo_pkg::addr_hit(paddr, pieo_pkg::CTRL_OFF);
  assign sel_flag   = pieo_pkg::addr_hit(paddr, pieo_pkg::FLAG_OFF);
  assign sel_enable = pieo_pkg::addr_hit(paddr, pieo_pkg::ENABLE_OFF);
  assign mapped     = sel_ctrl | sel_flag | sel_enable;
  assign setup      = psel & ~penable;

  // Read data and error are captured in setup so they come from flops
  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup)
    begin
      rdata_d = (mapped && !pwrite) ? rd_word : 32'h0000_0000;
      err_d   = ~mapped;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Zero wait states; unmapped writes are dropped
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign prdata  = rdata_q;
  assign wr_stb  = psel & penable & pwrite & mapped;

endmodule
`default_nettype wire

/* File: pieo_ctrl.sv */
// Peripheral interrupt enable register with flags, gating and APB access
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pieo_ctrl #(
  parameter bit HAS_PARALLEL_PORT = 1'b1
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Peripheral conditions, same clock
  input  wire logic [7:0]  SRC_COND,
  // Toward the core
  output logic      [7:0]  PERIPH_REQ,
  output logic             CORE_IRQ
);

  logic [31:0] rd_word;
  logic        sel_ctrl;
  logic        sel_flag;
  logic        sel_enable;
  logic        wr_stb;
  logic [7:0]  flags;
  logic [7:0]  flag_clr;
  logic [7:0]  en_keep;

  logic [7:0]  en_q;
  logic [7:0]  en_d;
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic [7:0]  req_q;
  logic [7:0]  req_d;
  logic        irq_q;
  logic        irq_d;
  logic        global_en;
  logic        group_en;

  // Bus front end
  pieo_apb_port #(
    .ADDR_W     (pieo_pkg::APB_ADDR_W)
  ) u_apb (
    .clk        (MCLK),
    .rst        (RST),
    .psel       (PSEL),
    .penable    (PENABLE),
    .pwrite     (PWRITE),
    .paddr      (PADDR),
    .prdata     (PRDATA),
    .pready     (PREADY),
    .pslverr    (PSLVERR),
    .rd_word    (rd_word),
    .sel_ctrl   (sel_ctrl),
    .sel_flag   (sel_flag),
    .sel_enable (sel_enable),
    .wr_stb     (wr_stb)
  );

  // Flags latch regardless of any enable; write one clears sticky ones
  assign flag_clr = (wr_stb && sel_flag) ? PWDATA[7:0] : 8'h00;

  pieo_flag_bank #(
    .WIDTH      (pieo_pkg::SRC_N),
    .LEVEL_BITS (pieo_pkg::LEVEL_MASK)
  ) u_flags (
    .clk        (MCLK),
    .rst        (RST),
    .cond       (SRC_COND),
    .clr        (flag_clr),
    .flags      (flags)
  );

  // Parallel port enable is held at zero on parts without the port
  assign en_keep = HAS_PARALLEL_PORT ? 8'hFF : 8'h7F;

  assign global_en = ctrl_q[1];
  assign group_en  = ctrl_q[0];

  // Enable and main control next values
  always_comb
  begin
    en_d   = en_q;
    ctrl_d = ctrl_q;
    if (wr_stb && sel_enable)
      en_d = PWDATA[7:0] & en_keep;
    if (wr_stb && sel_ctrl)
    begin
      ctrl_d[1] = PWDATA[pieo_pkg::GLOBAL_EN_BIT];
      ctrl_d[0] = PWDATA[pieo_pkg::GROUP_EN_BIT];
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      en_q   <= pieo_pkg::ENABLE_RST;
      ctrl_q <= pieo_pkg::CTRL_RST;
    end
    else
    begin
      en_q   <= en_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Request gating: own enable, then group, then global
  always_comb
  begin
    req_d = flags & en_q & {8{group_en}};
    irq_d = global_en & (|req_d);
  end

  // Registered so the core sees glitch-free levels, at one cycle of latency
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      req_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      req_q <= req_d;
      irq_q <= irq_d;
    end
  end

  assign PERIPH_REQ = req_q;
  assign CORE_IRQ   = irq_q;

  // Read mux; unused upper bits read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (sel_enable)
      rd_word[7:0] = en_q;
    else if (sel_flag)
      rd_word[7:0] = flags;
    else if (sel_ctrl)
    begin
      rd_word[pieo_pkg::GLOBAL_EN_BIT] = global_en;
      rd_word[pieo_pkg::GROUP_EN_BIT]  = group_en;
    end
  end

  // Checks on gating and flag behaviour

  own_enable_gate_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (PERIPH_REQ & ~$past(en_q)) == 8'h00
  ) else $error("request raised with its enable clear");

  group_block_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !$past(group_en) |-> PERIPH_REQ == 8'h00
  ) else $error("request passed with group enable clear");

  converter_pass_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (SRC_COND[6] && en_q[6] && group_en) ##1 (en_q[6] && group_en)
      |=> PERIPH_REQ[6]
  ) else $error("converter-done request missing");

  receive_pass_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (SRC_COND[5] && en_q[5] && group_en)[*2] |=> PERIPH_REQ[5]
  ) else $error("receive request missing while buffer full");

  flag_sets_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (SRC_COND[0] && !en_q[0] && !global_en) |=> flags[0]
  ) else $error("flag not set while interrupts disabled");

  global_block_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !$past(global_en) |-> !CORE_IRQ
  ) else $error("core interrupt with global enable clear");

  global_pass_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (global_en && ((flags & en_q) != 8'h00) && group_en) |=> CORE_IRQ
  ) else $error("unmasked interrupt not passed to core");

  port_bit_absent_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !HAS_PARALLEL_PORT |-> !en_q[7] && !PERIPH_REQ[7]
  ) else $error("parallel port enable set on part without port");

  // Checks on register writes; converter, receive, group and global bits are tried in both polarities, the parallel port bit only when written one

  converter_en_set_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_enable && PWDATA[pieo_pkg::CONVERTER_DONE_BIT])
      |=> en_q[pieo_pkg::CONVERTER_DONE_BIT]
  ) else $error("converter-done enable not set by write");

  converter_en_clear_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_enable && !PWDATA[pieo_pkg::CONVERTER_DONE_BIT])
      |=> !en_q[pieo_pkg::CONVERTER_DONE_BIT]
  ) else $error("converter-done enable not cleared by write");

  receive_en_set_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_enable && PWDATA[pieo_pkg::SERIAL_RX_BIT])
      |=> en_q[pieo_pkg::SERIAL_RX_BIT]
  ) else $error("receive enable not set by write");

  receive_en_clear_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_enable && !PWDATA[pieo_pkg::SERIAL_RX_BIT])
      |=> !en_q[pieo_pkg::SERIAL_RX_BIT]
  ) else $error("receive enable not cleared by write");

  port_en_write_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_enable && PWDATA[pieo_pkg::PARALLEL_PORT_BIT])
      |=> en_q[pieo_pkg::PARALLEL_PORT_BIT] == HAS_PARALLEL_PORT
  ) else $error("parallel port enable write not handled per build");

  enable_hold_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !(wr_stb && sel_enable) |=> $stable(en_q)
  ) else $error("enable register changed without a write");

  group_en_set_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_ctrl && PWDATA[pieo_pkg::GROUP_EN_BIT])
      |=> group_en
  ) else $error("group enable not set by write");

  group_en_clear_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_ctrl && !PWDATA[pieo_pkg::GROUP_EN_BIT])
      |=> !group_en
  ) else $error("group enable not cleared by write");

  global_en_set_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_ctrl && PWDATA[pieo_pkg::GLOBAL_EN_BIT])
      |=> global_en
  ) else $error("global enable not set by write");

  global_en_clear_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (wr_stb && sel_ctrl && !PWDATA[pieo_pkg::GLOBAL_EN_BIT])
      |=> !global_en
  ) else $error("global enable not cleared by write");

  ctrl_hold_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !(wr_stb && sel_ctrl) |=> $stable(ctrl_q)
  ) else $error("main control changed without a write");

  // Checks on flag storage and request passing; a condition during reset is not counted

  event_sets_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !$past(RST) |-> ($past(SRC_COND) & ~flags) == 8'h00
  ) else $error("flag not set after its condition");

  sticky_hold_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (($past(flags) & ~$past(flag_clr) & ~flags) & ~pieo_pkg::LEVEL_MASK) == 8'h00
  ) else $error("sticky flag lost without a clear");

  clear_lands_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (($past(flag_clr) & ~$past(SRC_COND) & flags) & ~pieo_pkg::LEVEL_MASK) == 8'h00
  ) else $error("sticky flag survived a clear with no new event");

  level_follow_a: assert property (
    @(posedge MCLK) disable iff (RST)
    !$past(RST) |-> ((flags ^ $past(SRC_COND)) & pieo_pkg::LEVEL_MASK) == 8'h00
  ) else $error("buffer-state flag does not follow its source");

  gated_pass_a: assert property (
    @(posedge MCLK) disable iff (RST)
    group_en |=> (($past(flags) & $past(en_q)) & ~PERIPH_REQ) == 8'h00
  ) else $error("enabled flag not passed as a request");

  irq_needs_req_a: assert property (
    @(posedge MCLK) disable iff (RST)
    CORE_IRQ |-> PERIPH_REQ != 8'h00
  ) else $error("core interrupt without any request");

  irq_follows_req_a: assert property (
    @(posedge MCLK) disable iff (RST)
    global_en |=> CORE_IRQ == (PERIPH_REQ != 8'h00)
  ) else $error("core interrupt does not follow requests");

  // Checks on the bus answer

  unmapped_error_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (PSEL && !PENABLE && !(sel_ctrl || sel_flag || sel_enable)) ##1 (PSEL && PENABLE)
      |-> PSLVERR && PRDATA == 32'h0000_0000
  ) else $error("unmapped access not answered with an error");

  mapped_no_error_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (PSEL && !PENABLE && (sel_ctrl || sel_flag || sel_enable)) ##1 (PSEL && PENABLE)
      |-> !PSLVERR
  ) else $error("mapped access answered with an error");

  enable_read_a: assert property (
    @(posedge MCLK) disable iff (RST)
    (PSEL && !PENABLE && !PWRITE && sel_enable)
      |=> PRDATA == {24'h000000, $past(en_q)}
  ) else $error("enable register read back wrong");

endmodule
`default_nettype wire

/* File: pieo_periph_model.sv */
// Peripheral condition source model for the enable block bench
`timescale 1ns/1ps
`default_nettype none
module pieo_periph_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Event requests and buffer states
  input  wire logic [7:0] events,
  input  wire logic       rx_full,
  input  wire logic       tx_empty,
  // Conditions toward the block
  output logic      [7:0] cond
);
  logic [7:0] cond_d;
  logic [7:0] cond_q;
  // Events as pulses, buffer states as levels
  always_comb
  begin
    cond_d = events & 8'hCF;
    cond_d[5] = rx_full;
    cond_d[4] = tx_empty;
  end
  // Registered so conditions change just after an edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cond_q <= 8'h00;
    else
      cond_q <= cond_d;
  end
  assign cond = cond_q;
endmodule
`default_nettype wire

/* File: test_pieo_ctrl.sv */
// Self-checking bench for the peripheral interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module test_pieo_ctrl;
  logic        MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CORE_IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, xs;
  logic [7:0]  SRC_COND, PERIPH_REQ, ev, en_m, ctl_m, fl_m, req_m, g, req_n;
  logic        rxf, txe, irq_m, irq_n, irq_nm;
  int          n_fail, checks;

  // Design and peripheral source
  pieo_ctrl pieo_ctrl_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SRC_COND(SRC_COND), .PERIPH_REQ(PERIPH_REQ), .CORE_IRQ(CORE_IRQ));
  pieo_periph_model pieo_periph_model_i (.clk(MCLK), .rst(RST), .events(ev),
    .rx_full(rxf), .tx_empty(txe), .cond(SRC_COND));

  // Build without the parallel port, same traffic; bit 7 writes test the forcing
  if (1'b1)
  begin : g_noport
    pieo_ctrl #(.HAS_PARALLEL_PORT(1'b0)) pieo_ctrl_i (.MCLK(MCLK), .RST(RST),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(), .PREADY(), .PSLVERR(), .SRC_COND(SRC_COND), .PERIPH_REQ(req_n),
      .CORE_IRQ(irq_n));
  end

  // 50 MHz clock
  always #10 MCLK = ~MCLK;

  task automatic err(input string s);
  begin
    n_fail++;
    $display("[ERR] %0t %s", $time, s);
  end
  endtask

  task automatic give_verdict();
  begin
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] x);
  begin
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  end
  endfunction

  // Reference model; gating uses the state from before this edge
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      en_m = pieo_pkg::ENABLE_RST;
      fl_m = pieo_pkg::FLAG_RST;
      ctl_m = 8'h00;
      req_m = 8'h00;
      irq_m = 1'b0;
      irq_nm = 1'b0;
    end
    else
    begin
      g = fl_m & en_m & {8{ctl_m[6]}};
      irq_m = ctl_m[7] & (|g);
      req_m = g;
      irq_nm = ctl_m[7] & (|(g & 8'h7F));
      if (PSEL && PENABLE && PWRITE && PADDR == pieo_pkg::ENABLE_OFF)
        en_m = PWDATA[7:0];
      if (PSEL && PENABLE && PWRITE && PADDR == pieo_pkg::CTRL_OFF)
        ctl_m = PWDATA[7:0] & 8'hC0;
      if (PSEL && PENABLE && PWRITE && PADDR == pieo_pkg::FLAG_OFF)
        fl_m = fl_m & ~PWDATA[7:0];
      // Set after clear, so a new event wins
      fl_m = (fl_m & 8'hCF) | SRC_COND;
    end
  end

  // Outputs settle by the falling edge
  always @(negedge MCLK)
  begin
    if (!RST)
    begin
      checks++;
      if (PERIPH_REQ !== req_m || CORE_IRQ !== irq_m)
        err("request or core line differs from model");
      checks++;
      if (req_n !== (req_m & 8'h7F) || irq_n !== irq_nm)
        err("portless build differs from model");
    end
  end

  // One APB transfer; read data is what the registers held in setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic [7:0] e;
    logic       bad;
    int         k;
  begin
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(negedge MCLK);
    bad = !(a inside {pieo_pkg::CTRL_OFF, pieo_pkg::FLAG_OFF, pieo_pkg::ENABLE_OFF});
    e = (a == pieo_pkg::CTRL_OFF) ? ctl_m : (a == pieo_pkg::FLAG_OFF) ? fl_m :
        (a == pieo_pkg::ENABLE_OFF) ? en_m : 8'h00;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    k = 0;
    do
    begin
      @(posedge MCLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 8);
    if (PREADY !== 1'b1)
    begin
      err("no ready");
      give_verdict();
    end
    checks++;
    if (PSLVERR !== bad || (!w && PRDATA !== {24'h000000, e}))
      err("register access differs from model");
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  end
  endtask

  initial
  begin
    MCLK = 1'b0;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h00000000;
    ev = 8'h00;
    rxf = 1'b0;
    txe = 1'b0;
    n_fail = 0;
    checks = 0;
    xs = 32'h0000B07B;
    // Two runs, the second after a reset at the end of the first run's traffic
    repeat (2)
    begin
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      apb(1'b0, pieo_pkg::ENABLE_OFF, 32'h00000000);
      apb(1'b0, pieo_pkg::CTRL_OFF, 32'h00000000);
      for (int i = 0; i < 600; i++)
      begin
        xs = xorshift(xs);
        ev <= xs[7:0] & {8{xs[8] & xs[9]}};
        rxf <= xs[10];
        txe <= xs[11];
        case (xs[14:12])
          3'h0: apb(1'b1, pieo_pkg::ENABLE_OFF, xs);
          3'h1: apb(1'b1, pieo_pkg::CTRL_OFF, xs);
          3'h2: apb(1'b1, pieo_pkg::FLAG_OFF, xs);
          3'h3: apb(1'b0, {8'h08, xs[16:15], 2'b00}, xs);
          3'h4: apb(1'b1, 12'h088, xs);
          default: @(posedge MCLK);
        endcase
      end
      @(posedge MCLK);
      RST <= 1'b1;
    end
    give_verdict();
  end
endmodule
`default_nettype wire
